// ===== include/dq_ref_pkg.sv
// constants for the dq reference level mode register
// assumes one command clock and 6-bit mode register addresses
package dq_ref_pkg;

    // mode register addressing
    localparam int MR_ADDR_W = 6;
    localparam logic [MR_ADDR_W-1:0] ADDR_DQ_REF_LEVEL = 6'h0e;

    // register layout
    localparam int DATA_W = 8;
    localparam int CODE_W = 6;
    localparam int CODE_LSB = 0;
    localparam int RANGE_BIT = 6;
    localparam int RESERVED_BIT = 7;
    localparam int WORD_W = 7;

    // valid level codes stop here; higher codes are reserved
    localparam logic [CODE_W-1:0] CODE_MAX = 6'h32;

    // reset values
    localparam logic [CODE_W-1:0] CODE_RESET = 6'h0d;
    localparam logic RANGE_RESET = 1'b1;
    localparam logic [WORD_W-1:0] WORD_RESET = {RANGE_RESET, CODE_RESET};
    localparam logic [DATA_W-1:0] REG_RESET = 8'h4d;

    // set points
    localparam int NUM_SET_POINTS = 2;

    // reference level in tenths of a percent of the dq supply
    localparam int VREF_W = 10;
    localparam logic [VREF_W-1:0] VREF_BASE_R0_PM = 10'h064;
    localparam logic [VREF_W-1:0] VREF_BASE_R1_PM = 10'h0dc;
    localparam logic [VREF_W-1:0] VREF_STEP_PM = 10'h004;
    localparam logic [VREF_W-1:0] VREF_RESET_PM =
        VREF_BASE_R1_PM + VREF_STEP_PM * {4'h0, CODE_RESET};

    typedef logic [WORD_W-1:0] ref_word_t;

endpackage

// ===== include/dq_ref_copy_if.sv
// connection between the register front end and the set-point copy bank
// assumes both ends run on the same command clock
`timescale 1ns/1ps
`default_nettype none

interface dq_ref_copy_if #(
    parameter int NUM_SP = dq_ref_pkg::NUM_SET_POINTS
);
    localparam int SEL_W = (NUM_SP > 1) ? $clog2(NUM_SP) : 1;

    logic wr_en;
    logic [SEL_W-1:0] wr_sel;
    dq_ref_pkg::ref_word_t wr_word;
    logic [SEL_W-1:0] rd_sel;
    dq_ref_pkg::ref_word_t rd_word;
    logic [SEL_W-1:0] op_sel;
    dq_ref_pkg::ref_word_t op_word;

    modport bank (
        input wr_en,
        input wr_sel,
        input wr_word,
        input rd_sel,
        input op_sel,
        output rd_word,
        output op_word
    );

    modport user (
        output wr_en,
        output wr_sel,
        output wr_word,
        output rd_sel,
        output op_sel,
        input rd_word,
        input op_word
    );

endinterface

`default_nettype wire

// ===== design/dq_ref_copy_bank.sv
// per-set-point physical copies of the reference word
// assumes select inputs come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module dq_ref_copy_bank #(
    parameter int NUM_SP = dq_ref_pkg::NUM_SET_POINTS
) (
    input wire logic clk_sys_in,     // command clock
    input wire logic rstn_in,        // async reset, active low
    dq_ref_copy_if.bank copy_bus     // write, read and operate ports
);

    dq_ref_pkg::ref_word_t copy_d [NUM_SP];
    dq_ref_pkg::ref_word_t copy_q [NUM_SP];

    ////////////////////////////////////////////////////////////////////////
    // one copy per set point
    for (genvar sp = 0; sp < NUM_SP; sp++)
    begin : g_copy
        always_comb
        begin
            copy_d[sp] = copy_q[sp];
            // only the access-selected copy takes the write
            if (copy_bus.wr_en && (int'(copy_bus.wr_sel) == sp))
            begin
                copy_d[sp] = copy_bus.wr_word; // [RULE5] [RULE8]
            end
        end

        always_ff @(posedge clk_sys_in or negedge rstn_in)
        begin
            if (!rstn_in)
            begin
                copy_q[sp] <= dq_ref_pkg::WORD_RESET; // [RULE11]
            end
            else
            begin
                copy_q[sp] <= copy_d[sp]; // [RULE7]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read and operate selection
    always_comb
    begin
        copy_bus.rd_word = copy_q[copy_bus.rd_sel]; // [RULE8]
        copy_bus.op_word = copy_q[copy_bus.op_sel]; // [RULE9]
    end

endmodule // dq_ref_copy_bank

`default_nettype wire

// ===== design/dq_reference_level.sv
// dq reference level mode register: command decode, read driver, operating level
// assumes commands and set-point selects come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE1 - bits 5..0 hold the level code; codes above 110010 are reserved
// RULE2 - bit 6 picks reference range 0 or 1; range 1 after reset
// RULE3 - a register read places bits 7..0 onto dq 7..0
// RULE4 - on a read, bit 7 and any unused dq line return zero
// RULE5 - a write updates set point 0 or 1 copy per the access select
// RULE6 - controller gives range and level code together in one write
// RULE7 - written values hold until rewritten or reset
// RULE8 - two copies per bit; reads and writes reach the access-selected copy
// RULE9 - operation uses only the active-selected copy; the other is ignored
// RULE10 - level is 10.0% or 22.0% plus 0.4% per code step; default 001101
// RULE11 - reset loads both copies with range 1 and code 001101, reading 0x4d
module dq_reference_level #(
    parameter int NUM_SP = dq_ref_pkg::NUM_SET_POINTS
) (
    input wire logic clk_sys_in,                                  // command clock, 125 MHz
    input wire logic rstn_in,                                     // async reset, active low
    input wire logic mrw_valid_in,                                // mode register write command
    input wire logic mrr_valid_in,                                // mode register read command
    input wire logic [dq_ref_pkg::MR_ADDR_W-1:0] mr_addr_in,      // mode register address
    input wire logic [dq_ref_pkg::DATA_W-1:0] mr_wdata_in,        // write operand
    input wire logic set_point_access_sel_in,                     // copy reached by commands
    input wire logic set_point_active_sel_in,                     // copy used for operation
    output logic [dq_ref_pkg::DATA_W-1:0] dq_out,                 // read data onto dq
    output logic dq_oe_n_out,                                     // dq drive enable, low drives
    output logic mrr_data_valid_out,                              // read data present
    output logic [dq_ref_pkg::CODE_W-1:0] active_level_code_out,  // operating level code
    output logic active_range_out,                                // operating range select
    output logic [dq_ref_pkg::VREF_W-1:0] active_vref_pm_out,     // level, tenths of a percent
    output logic active_code_reserved_out                         // operating code is reserved
);

    typedef enum logic [0:0] {
        RD_IDLE,
        RD_DRIVE
    } rd_state_t;

    localparam int SEL_W = (NUM_SP > 1) ? $clog2(NUM_SP) : 1;

    dq_ref_copy_if #(.NUM_SP(NUM_SP)) copy_bus ();

    logic addr_hit;
    logic rd_hit;

    rd_state_t rd_state_d;
    rd_state_t rd_state_q;
    logic [dq_ref_pkg::DATA_W-1:0] dq_d;
    logic [dq_ref_pkg::DATA_W-1:0] dq_q;
    logic dq_oe_n_d;
    logic dq_oe_n_q;

    logic [dq_ref_pkg::CODE_W-1:0] op_code_d;
    logic [dq_ref_pkg::CODE_W-1:0] op_code_q;
    logic op_range_d;
    logic op_range_q;
    logic [dq_ref_pkg::VREF_W-1:0] op_vref_d;
    logic [dq_ref_pkg::VREF_W-1:0] op_vref_q;
    logic op_reserved_d;
    logic op_reserved_q;

    ////////////////////////////////////////////////////////////////////////
    // command decode towards the copy bank
    always_comb
    begin
        addr_hit = (mr_addr_in == dq_ref_pkg::ADDR_DQ_REF_LEVEL);
        rd_hit = mrr_valid_in && addr_hit;
        copy_bus.wr_en = mrw_valid_in && addr_hit;
        copy_bus.wr_sel = SEL_W'(set_point_access_sel_in); // [RULE5]
        // range and code land together; the reserved bit is dropped
        copy_bus.wr_word = mr_wdata_in[dq_ref_pkg::WORD_W-1:0]; // [RULE6] [RULE1] [RULE2]
        copy_bus.rd_sel = SEL_W'(set_point_access_sel_in); // [RULE8]
        copy_bus.op_sel = SEL_W'(set_point_active_sel_in); // [RULE9]
    end

    dq_ref_copy_bank #(
        .NUM_SP(NUM_SP)
    ) u_copy_bank (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .copy_bus(copy_bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // read driver: one cycle of data per accepted read
    always_comb
    begin
        rd_state_d = RD_IDLE;
        dq_d = '0;
        dq_oe_n_d = 1'b1;
        if (rd_hit)
        begin
            rd_state_d = RD_DRIVE;
            dq_oe_n_d = 1'b0;
            dq_d[dq_ref_pkg::WORD_W-1:0] = copy_bus.rd_word; // [RULE3]
            dq_d[dq_ref_pkg::RESERVED_BIT] = 1'b0; // [RULE4]
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rd_state_q <= RD_IDLE;
            dq_q <= '0;
            dq_oe_n_q <= 1'b1;
        end
        else
        begin
            rd_state_q <= rd_state_d;
            dq_q <= dq_d;
            dq_oe_n_q <= dq_oe_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // operating level from the active copy
    always_comb
    begin
        op_code_d = copy_bus.op_word[dq_ref_pkg::CODE_LSB +: dq_ref_pkg::CODE_W]; // [RULE1]
        op_range_d = copy_bus.op_word[dq_ref_pkg::RANGE_BIT]; // [RULE2]
        op_reserved_d = (op_code_d > dq_ref_pkg::CODE_MAX); // [RULE1]
        // linear map from the range base in 0.4 percent steps
        unique case (op_range_d)
            1'b0:
            begin
                op_vref_d = dq_ref_pkg::VREF_BASE_R0_PM
                    + VREF_MUL(op_code_d); // [RULE10]
            end
            1'b1:
            begin
                op_vref_d = dq_ref_pkg::VREF_BASE_R1_PM
                    + VREF_MUL(op_code_d); // [RULE10]
            end
        endcase
    end

    function automatic logic [dq_ref_pkg::VREF_W-1:0] VREF_MUL(
        input logic [dq_ref_pkg::CODE_W-1:0] code
    );
        logic [dq_ref_pkg::VREF_W-1:0] wide;
        wide = {{(dq_ref_pkg::VREF_W - dq_ref_pkg::CODE_W){1'b0}}, code};
        return dq_ref_pkg::VREF_W'(wide * dq_ref_pkg::VREF_STEP_PM);
    endfunction

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            op_code_q <= dq_ref_pkg::CODE_RESET; // [RULE11]
            op_range_q <= dq_ref_pkg::RANGE_RESET; // [RULE11]
            op_vref_q <= dq_ref_pkg::VREF_RESET_PM; // [RULE10]
            op_reserved_q <= 1'b0;
        end
        else
        begin
            op_code_q <= op_code_d;
            op_range_q <= op_range_d;
            op_vref_q <= op_vref_d;
            op_reserved_q <= op_reserved_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    always_comb
    begin
        dq_out = dq_q;
        dq_oe_n_out = dq_oe_n_q;
        mrr_data_valid_out = (rd_state_q == RD_DRIVE);
        active_level_code_out = op_code_q;
        active_range_out = op_range_q;
        active_vref_pm_out = op_vref_q;
        active_code_reserved_out = op_reserved_q;
    end

endmodule // dq_reference_level

`default_nettype wire

// ===== sim/mr_ctrl_model.sv
// controller model issuing one-cycle mode register commands
// assumes the device samples commands on the rising clock edge
`timescale 1ns/1ps
`default_nettype none

module mr_ctrl_model (
    input wire logic clk_sys_in,     // command clock
    output logic mrw_out,            // write pulse
    output logic mrr_out,            // read pulse
    output logic [5:0] addr_out,     // register address
    output logic [7:0] wdata_out     // write operand
);
    initial {mrw_out, mrr_out, addr_out, wdata_out} = 16'h0000;

    task automatic cmd(input logic wr, input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        mrw_out = wr;
        mrr_out = !wr;
        addr_out = a;
        wdata_out = d;
        @(negedge clk_sys_in);
        mrw_out = 1'b0;
        mrr_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
    endtask
endmodule // mr_ctrl_model

`default_nettype wire

// ===== sim/dq_ref_checker.sv
// assertions on the dq reference level register ports
// assumes one command clock and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none

module dq_ref_checker #(
    parameter int NUM_SP = dq_ref_pkg::NUM_SET_POINTS
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic mrw_valid_in,
    input wire logic mrr_valid_in,
    input wire logic [5:0] mr_addr_in,
    input wire logic [7:0] mr_wdata_in,
    input wire logic set_point_access_sel_in,
    input wire logic set_point_active_sel_in,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe_n_out,
    input wire logic mrr_data_valid_out,
    input wire logic [5:0] active_level_code_out,
    input wire logic active_range_out,
    input wire logic [9:0] active_vref_pm_out,
    input wire logic active_code_reserved_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);
    logic rd_hit;
    logic same_sel;
    logic [6:0] wword;
    assign rd_hit = mrr_valid_in && mr_addr_in == dq_ref_pkg::ADDR_DQ_REF_LEVEL;
    assign same_sel = set_point_access_sel_in == set_point_active_sel_in;
    assign wword = mr_wdata_in[6:0];
    ////////////////////////////////////////
    chk_read_answer:
        assert property (rd_hit |=> mrr_data_valid_out && !dq_oe_n_out) else $error("read not answered");
    chk_no_answer:
        assert property (!rd_hit |=> dq_oe_n_out && !mrr_data_valid_out) else $error("unrequested answer");
    chk_idle_zero:
        assert property (dq_oe_n_out |-> dq_out == 8'h00) else $error("dq not zero when idle");
    chk_top_bit:
        assert property (mrr_data_valid_out |-> !dq_out[7]) else $error("bit 7 read as one");
    chk_vref_map:
        assert property (active_vref_pm_out == (active_range_out ? 10'h0dc : 10'h064) + 10'h004 * active_level_code_out)
        else $error("vref does not match code");
    chk_resv_flag:
        assert property (active_code_reserved_out == (active_level_code_out > 6'h32)) else $error("reserved flag wrong");
    chk_active_hold:
        assert property (!mrw_valid_in && !$past(mrw_valid_in) && $stable(set_point_active_sel_in)
            |=> $stable({active_range_out, active_level_code_out})) else $error("active value moved");
    chk_write_active:
        assert property (mrw_valid_in && mr_addr_in == dq_ref_pkg::ADDR_DQ_REF_LEVEL && same_sel
            ##1 $stable(set_point_active_sel_in) |=> {active_range_out, active_level_code_out} == $past(wword, 2))
        else $error("write not seen on active copy");
    chk_read_active:
        assert property (rd_hit && same_sel && !$past(mrw_valid_in) && $stable(set_point_active_sel_in)
            |=> dq_out == {1'b0, $past(active_range_out), $past(active_level_code_out)})
        else $error("read copy differs from active");
    cov_read: cover property (rd_hit);
    cov_write: cover property (mrw_valid_in && mr_addr_in == dq_ref_pkg::ADDR_DQ_REF_LEVEL);
    cov_reserved: cover property (active_code_reserved_out);
endmodule // dq_ref_checker

bind dq_reference_level dq_ref_checker #(.NUM_SP(NUM_SP)) u_chk (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .mrw_valid_in(mrw_valid_in), .mrr_valid_in(mrr_valid_in),
    .mr_addr_in(mr_addr_in), .mr_wdata_in(mr_wdata_in), .set_point_access_sel_in(set_point_access_sel_in),
    .set_point_active_sel_in(set_point_active_sel_in), .dq_out(dq_out), .dq_oe_n_out(dq_oe_n_out),
    .mrr_data_valid_out(mrr_data_valid_out), .active_level_code_out(active_level_code_out),
    .active_range_out(active_range_out), .active_vref_pm_out(active_vref_pm_out),
    .active_code_reserved_out(active_code_reserved_out));

`default_nettype wire

// ===== sim/tb_top.sv
// testbench for the dq reference level register
// assumes the controller model drives commands at the falling edge
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b0;
    logic access_sel = 1'b0;
    logic active_sel = 1'b0;
    logic mrw, mrr, oe_n, vld, rng, resv;
    logic [5:0] addr, code;
    logic [7:0] wdata, dq;
    logic [9:0] vref;
    int bad_count = 0;
    int num_checks = 0;

    always #4 clk_sys_in = ~clk_sys_in;

    mr_ctrl_model u_ctrl (.clk_sys_in(clk_sys_in), .mrw_out(mrw), .mrr_out(mrr), .addr_out(addr), .wdata_out(wdata));
    dq_reference_level u_dut (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .mrw_valid_in(mrw), .mrr_valid_in(mrr), .mr_addr_in(addr),
        .mr_wdata_in(wdata), .set_point_access_sel_in(access_sel), .set_point_active_sel_in(active_sel),
        .dq_out(dq), .dq_oe_n_out(oe_n), .mrr_data_valid_out(vld), .active_level_code_out(code),
        .active_range_out(rng), .active_vref_pm_out(vref), .active_code_reserved_out(resv));
    ////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rd(input logic [7:0] exp);
        u_ctrl.cmd(1'b0, dq_ref_pkg::ADDR_DQ_REF_LEVEL, 8'h00);
        // answer stands only in the cycle after the taking edge
        cmp({oe_n, vld, dq}, {2'b01, exp});
        @(negedge clk_sys_in);
        cmp({oe_n, vld, dq}, 10'h200);
    endtask

    task automatic chk_act(input logic r, input logic [5:0] c);
        @(negedge clk_sys_in);
        cmp({3'h0, rng, code}, {3'h0, r, c});
        cmp(vref, (r ? 10'h0dc : 10'h064) + 10'h004 * {4'h0, c});
        cmp({9'h000, resv}, {9'h000, c > 6'h32});
    endtask

    initial
    begin
        repeat (2000) @(posedge clk_sys_in);
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        stop_test();
    end

    initial
    begin
        repeat (10) @(negedge clk_sys_in);
        rstn_in = 1'b1;
        chk_act(1'b1, 6'h0d);
        chk_rd(8'h4d);
        access_sel = 1'b1;
        chk_rd(8'h4d);
        access_sel = 1'b0;
        u_ctrl.cmd(1'b1, 6'h0e, 8'ha5);
        chk_act(1'b0, 6'h25);
        chk_rd(8'h25);
        access_sel = 1'b1;
        u_ctrl.cmd(1'b1, 6'h0e, 8'h72);
        chk_act(1'b0, 6'h25);
        chk_rd(8'h72);
        active_sel = 1'b1;
        chk_act(1'b1, 6'h32);
        u_ctrl.cmd(1'b1, 6'h0e, 8'h33);
        chk_act(1'b0, 6'h33);
        access_sel = 1'b0;
        chk_rd(8'h25);
        u_ctrl.cmd(1'b0, 6'h0f, 8'h00);
        cmp({oe_n, vld, dq}, 10'h200);
        @(negedge clk_sys_in);
        cmp({oe_n, vld, dq}, 10'h200);
        u_ctrl.cmd(1'b1, 6'h0f, 8'h11);
        chk_rd(8'h25);
        rstn_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        rstn_in = 1'b1;
        chk_act(1'b1, 6'h0d);
        access_sel = 1'b1;
        chk_rd(8'h4d);
        stop_test();
    end
endmodule // tb_top

`default_nettype wire
